// ==== hw/aging_timer.sv ====
// Address-table aging period timer with normal and fast periods
`timescale 1ns/1ps
module aging_timer #(
  parameter logic [35:0] NORMAL_CYCLES = 36'h0,
  parameter logic [35:0] FAST_CYCLES   = 36'h0
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_enable,
  input  wire logic i_fast,
  output logic      o_tick,
  output logic      o_fast_active
);

  switch_policy_pkg::age_mode_t mode_reg;
  switch_policy_pkg::age_mode_t mode_next;
  logic [35:0]                  cnt_reg;
  logic [35:0]                  cnt_next;
  logic                         tick_reg;
  logic                         tick_next;
  logic [35:0]                  period;

  always_comb begin
    period    = (mode_reg == switch_policy_pkg::AGE_FAST) ? FAST_CYCLES : NORMAL_CYCLES;
    cnt_next  = cnt_reg + 36'h1;
    tick_next = 1'b0;
    mode_next = mode_reg;
    if (!i_enable) begin
      cnt_next  = 36'h0;
      mode_next = i_fast ? switch_policy_pkg::AGE_FAST : switch_policy_pkg::AGE_NORMAL;
    end else if (cnt_reg >= period - 36'h1) begin
      // period end: take the mode from i_fast
      // While enabled, the mode is only changed at a period boundary so no cycle is cut short
      cnt_next  = 36'h0;
      tick_next = 1'b1;
      mode_next = i_fast ? switch_policy_pkg::AGE_FAST : switch_policy_pkg::AGE_NORMAL;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_reg <= switch_policy_pkg::AGE_NORMAL;
      cnt_reg  <= 36'h0;
      tick_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign o_tick        = tick_reg;
  assign o_fast_active = (mode_reg == switch_policy_pkg::AGE_FAST);

endmodule : aging_timer

// ==== hw/switch_global_policy_controls.sv ====
// Global policy control registers and the per-frame policy decisions they steer
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "switch_policy_params.svh"

// Overview of operation
// - Aging enable bit runs the aging timer
// - Aging bit resets from aging strap pin
// - Fast age bit selects 800 us period
// - Aggressive bit selects non-standard half-duplex back-off
// - Aggressive bit resets from back-off strap
// - Strict bit stops all port-VLAN crossing
// - Clear strict bit lets known unicast cross
// - Exclude bit limits storm control to broadcast
// - Clear exclude bit also limits multicast frames
// - Back-pressure mode bit, reset one
// - Fair mode may drop non-flow-controlled frames
// - Unfair mode flow-controls the capable port
// - Drop after sixteen collisions unless bit set
// - Collision drop bit resets from its strap
// - Normal aging period about 300 seconds
module switch_global_policy_controls #(
  parameter logic [35:0] AGE_NORMAL_CYCLES = `AGE_NORMAL_CYCLES,
  parameter logic [35:0] AGE_FAST_CYCLES   = `AGE_FAST_CYCLES
) (
  input  wire logic                             i_clk,
  input  wire logic                             i_rst,
  input  wire logic [7:0]                       i_addr,
  input  wire logic [7:0]                       i_wdata,
  input  wire logic                             i_wr,
  input  wire logic                             i_rd,
  output logic      [7:0]                       o_rdata,
  input  wire logic                             i_aging_strap_pin,
  input  wire logic                             i_backoff_strap_pin,
  input  wire logic                             i_collision_drop_strap_pin,
  input  wire switch_policy_pkg::frame_query_t  i_query,
  output switch_policy_pkg::verdict_t           o_verdict,
  output switch_policy_pkg::policy_t            o_policy,
  output logic                                  o_age_tick,
  output logic                                  o_fast_age_active
);

  function automatic logic [1:0] reg_sel(input logic [7:0] addr);
    logic [1:0] sel;
    sel = 2'b00;
    if (addr == `ADDR_CTRL_A) begin
      sel = 2'b01;
    end else if (addr == `ADDR_CTRL_B) begin
      sel = 2'b10;
    end
    return sel;
  endfunction : reg_sel

  // Strap synchronisers run without reset so they track the pins during reset
  logic [2:0] strap_s1_reg;
  logic [2:0] strap_s2_reg;

  always_ff @(posedge i_clk) begin
    strap_s1_reg <= {i_collision_drop_strap_pin, i_backoff_strap_pin, i_aging_strap_pin};
    strap_s2_reg <= strap_s1_reg;
  end

  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_a_next;
  logic [7:0] ctrl_b_reg;
  logic [7:0] ctrl_b_next;
  logic       loaded_reg;
  logic       loaded_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [1:0] wsel;
  logic [1:0] rsel;

  always_comb begin
    wsel        = i_wr ? reg_sel(i_addr) : 2'b00;
    rsel        = i_rd ? reg_sel(i_addr) : 2'b00;
    ctrl_a_next = ctrl_a_reg;
    ctrl_b_next = ctrl_b_reg;
    loaded_next = 1'b1;
    if (!loaded_reg) begin
      ctrl_a_next[`A_AGING]       = strap_s2_reg[0];
      ctrl_a_next[`A_AGGR]        = strap_s2_reg[1];
      ctrl_b_next[`B_NO_COL_DROP] = strap_s2_reg[2];
    end
    // software write
    // A write in the load cycle wins over the strap value
    if (wsel[0]) begin
      ctrl_a_next = i_wdata & `CTRL_A_MASK;
    end
    if (wsel[1]) begin
      ctrl_b_next = i_wdata & `CTRL_B_MASK;
    end
    rdata_next = 8'h00;
    if (rsel[0]) begin
      rdata_next = ctrl_a_reg;
    end else if (rsel[1]) begin
      rdata_next = ctrl_b_reg;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_a_reg <= `CTRL_A_RST;
      ctrl_b_reg <= `CTRL_B_RST;
      loaded_reg <= 1'b0;
      rdata_reg  <= 8'h00;
    end else begin
      ctrl_a_reg <= ctrl_a_next;
      ctrl_b_reg <= ctrl_b_next;
      loaded_reg <= loaded_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;

  always_comb begin
    o_policy.aging_en           = ctrl_a_reg[`A_AGING];
    o_policy.fast_age           = ctrl_a_reg[`A_FAST];
    o_policy.aggressive_backoff = ctrl_a_reg[`A_AGGR];
    o_policy.vlan_strict        = ctrl_b_reg[`B_VLAN_STRICT];
    o_policy.mcast_storm_excl   = ctrl_b_reg[`B_MC_EXCL];
    o_policy.bp_carrier         = ctrl_b_reg[`B_BP_CARRIER];
    o_policy.fair_mode          = ctrl_b_reg[`B_FAIR];
    o_policy.no_collision_drop  = ctrl_b_reg[`B_NO_COL_DROP];
  end

  aging_timer #(
    .NORMAL_CYCLES (AGE_NORMAL_CYCLES),
    .FAST_CYCLES   (AGE_FAST_CYCLES)
  ) u_aging_timer (
    .i_clk         (i_clk),
    .i_rst         (i_rst),
    .i_enable      (ctrl_a_reg[`A_AGING]),
    .i_fast        (ctrl_a_reg[`A_FAST]),
    .o_tick        (o_age_tick),
    .o_fast_active (o_fast_age_active)
  );

  switch_policy_pkg::verdict_t verdict_reg;
  switch_policy_pkg::verdict_t verdict_next;
  logic                        is_bcast;
  logic                        is_mcast;

  always_comb begin
    is_bcast                     = (i_query.da == `DA_BROADCAST);
    is_mcast                     = i_query.da[`DA_MCAST_BIT];
    verdict_next                 = '0;
    verdict_next.valid           = i_query.valid;
    verdict_next.storm_regulated = is_bcast | (is_mcast & ~ctrl_b_reg[`B_MC_EXCL]);
    // known unicast crosses
    // Unknown unicast must flood inside its VLAN even when crossing is allowed
    verdict_next.vlan_permit     = ~i_query.crosses_vlan |
                                   (~ctrl_b_reg[`B_VLAN_STRICT] & i_query.known_unicast &
                                    ~is_mcast);
    verdict_next.collision_drop  = (i_query.collisions >= `COLLISION_LIMIT) &
                                   ~ctrl_b_reg[`B_NO_COL_DROP];
    verdict_next.drop_nonfc      = i_query.fc_contend & ctrl_b_reg[`B_FAIR];
    verdict_next.flow_ctrl_fc    = i_query.fc_contend & ~ctrl_b_reg[`B_FAIR];
    if (!i_query.valid) begin
      verdict_next = '0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      verdict_reg <= '0;
    end else begin
      verdict_reg <= verdict_next;
    end
  end

  assign o_verdict = verdict_reg;

  // Assertions

  a_aging_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    o_age_tick |-> $past(ctrl_a_reg[`A_AGING]))
    else $error("Aging tick while aging disabled");

  a_strap_load: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(loaded_reg) && !$past(wsel[0]) && !$past(wsel[1]) |->
      ctrl_a_reg[`A_AGING] == $past(strap_s2_reg[0]) &&
      ctrl_a_reg[`A_AGGR] == $past(strap_s2_reg[1]) &&
      ctrl_b_reg[`B_NO_COL_DROP] == $past(strap_s2_reg[2]))
    else $error("Strap value not loaded at reset release");

  a_fast_select: assert property (@(posedge i_clk) disable iff (i_rst)
    o_age_tick && o_fast_age_active |-> $past(ctrl_a_reg[`A_FAST], 1) || ctrl_a_reg[`A_FAST]
      || $past(ctrl_a_reg[`A_FAST], 2))
    else $error("Fast aging without fast age bit");

  a_storm_class: assert property (@(posedge i_clk) disable iff (i_rst)
    i_query.valid && i_query.da[`DA_MCAST_BIT] && !ctrl_b_reg[`B_MC_EXCL] |=>
      o_verdict.storm_regulated)
    else $error("Multicast frame not storm regulated");

  a_storm_excl: assert property (@(posedge i_clk) disable iff (i_rst)
    i_query.valid && ctrl_b_reg[`B_MC_EXCL] && i_query.da != `DA_BROADCAST |=>
      !o_verdict.storm_regulated)
    else $error("Non-broadcast frame regulated while multicast excluded");

  a_vlan_strict: assert property (@(posedge i_clk) disable iff (i_rst)
    i_query.valid && i_query.crosses_vlan && ctrl_b_reg[`B_VLAN_STRICT] |=>
      o_verdict.valid && !o_verdict.vlan_permit)
    else $error("Frame crossed port VLAN in strict mode");

  a_vlan_unicast: assert property (@(posedge i_clk) disable iff (i_rst)
    i_query.valid && i_query.crosses_vlan && !ctrl_b_reg[`B_VLAN_STRICT] |=>
      o_verdict.vlan_permit == ($past(i_query.known_unicast) &&
                                !$past(i_query.da[`DA_MCAST_BIT])))
    else $error("Unicast crossing decision wrong");

  a_collision_drop: assert property (@(posedge i_clk) disable iff (i_rst)
    i_query.valid |=> o_verdict.collision_drop ==
      ($past(i_query.collisions) >= `COLLISION_LIMIT && !$past(ctrl_b_reg[`B_NO_COL_DROP])))
    else $error("Excessive collision drop decision wrong");

  a_fair_choice: assert property (@(posedge i_clk) disable iff (i_rst)
    i_query.valid && i_query.fc_contend |=>
      o_verdict.drop_nonfc == $past(ctrl_b_reg[`B_FAIR]) &&
      o_verdict.flow_ctrl_fc == !$past(ctrl_b_reg[`B_FAIR]))
    else $error("Fair mode contention decision wrong");

  a_bp_write: assert property (@(posedge i_clk) disable iff (i_rst)
    i_wr && i_addr == `ADDR_CTRL_B |=> o_policy.bp_carrier == $past(i_wdata[`B_BP_CARRIER]))
    else $error("Back-pressure mode not written");

  a_reg_readback: assert property (@(posedge i_clk) disable iff (i_rst)
    i_wr && i_addr == `ADDR_CTRL_A ##1 i_rd && i_addr == `ADDR_CTRL_A && !i_wr |=>
      o_rdata == ($past(i_wdata, 2) & `CTRL_A_MASK))
    else $error("Read did not return last written value");

  a_rdata_idle: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rd |=> o_rdata == 8'h00)
    else $error("Read data present without a read");

  a_rdata_unmapped: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rd && i_addr != `ADDR_CTRL_A && i_addr != `ADDR_CTRL_B |=> o_rdata == 8'h00)
    else $error("Unmapped read returned data");

  a_aging_write: assert property (@(posedge i_clk) disable iff (i_rst)
    i_wr && i_addr == `ADDR_CTRL_A |=> o_policy.aging_en == $past(i_wdata[`A_AGING]))
    else $error("Aging enable not written");

  a_fast_write: assert property (@(posedge i_clk) disable iff (i_rst)
    i_wr && i_addr == `ADDR_CTRL_A |=> o_policy.fast_age == $past(i_wdata[`A_FAST]))
    else $error("Fast age enable not written");

  a_backoff_write: assert property (@(posedge i_clk) disable iff (i_rst)
    i_wr && i_addr == `ADDR_CTRL_A |=> o_policy.aggressive_backoff == $past(i_wdata[`A_AGGR]))
    else $error("Back-off style not written");

  a_excl_write: assert property (@(posedge i_clk) disable iff (i_rst)
    i_wr && i_addr == `ADDR_CTRL_B |=> o_policy.mcast_storm_excl == $past(i_wdata[`B_MC_EXCL]))
    else $error("Multicast storm exclusion not written");

  a_vlan_local: assert property (@(posedge i_clk) disable iff (i_rst)
    i_query.valid && !i_query.crosses_vlan |=> o_verdict.valid && o_verdict.vlan_permit)
    else $error("Frame inside its port VLAN refused");

  a_fc_unfair: assert property (@(posedge i_clk) disable iff (i_rst)
    i_query.valid && i_query.fc_contend && !ctrl_b_reg[`B_FAIR] |=>
      o_verdict.flow_ctrl_fc && !o_verdict.drop_nonfc)
    else $error("Unfair mode did not flow-control the capable port");

  a_tick_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
    o_age_tick |=> !o_age_tick)
    else $error("Aging tick longer than one cycle");

  c_fast_tick: cover property (@(posedge i_clk) disable iff (i_rst)
    o_age_tick && o_fast_age_active);

  c_mcast_storm: cover property (@(posedge i_clk) disable iff (i_rst)
    o_verdict.valid && o_verdict.storm_regulated && !ctrl_b_reg[`B_MC_EXCL]);

  c_collision_drop: cover property (@(posedge i_clk) disable iff (i_rst)
    o_verdict.collision_drop);

  c_strap_load: cover property (@(posedge i_clk) disable iff (i_rst)
    $rose(loaded_reg) && ctrl_a_reg[`A_AGGR]);

  c_fair_drop: cover property (@(posedge i_clk) disable iff (i_rst)
    o_verdict.valid && o_verdict.drop_nonfc);

endmodule : switch_global_policy_controls

// ==== hw/switch_policy_params.svh ====
// Offsets, field positions, reset values and timing counts of the global policy controls
`ifndef SWITCH_POLICY_PARAMS_SVH
`define SWITCH_POLICY_PARAMS_SVH

`define CLK_MHZ            200

`define ADDR_CTRL_A        8'h03
`define ADDR_CTRL_B        8'h04

`define CTRL_A_MASK        8'h07
`define CTRL_B_MASK        8'hf8
`define CTRL_A_RST         8'h04
`define CTRL_B_RST         8'hf0

`define A_AGING            2
`define A_FAST             1
`define A_AGGR             0
`define B_VLAN_STRICT      7
`define B_MC_EXCL          6
`define B_BP_CARRIER       5
`define B_FAIR             4
`define B_NO_COL_DROP      3

`define DA_MCAST_BIT       40
`define DA_BROADCAST       48'hffffffffffff
`define COLLISION_LIMIT    5'h10

`define AGE_FAST_US        800
`define AGE_NORMAL_S       300
`define AGE_FAST_CYCLES    (36'd`AGE_FAST_US * 36'd`CLK_MHZ)
`define AGE_NORMAL_CYCLES  (36'd`AGE_NORMAL_S * 36'd1000000 * 36'd`CLK_MHZ)

`endif

// ==== hw/switch_policy_pkg.sv ====
// Types shared by the global policy controls
package switch_policy_pkg;

  typedef struct packed {
    logic        valid;
    logic [47:0] da;
    logic        known_unicast;
    logic        crosses_vlan;
    logic [4:0]  collisions;
    logic        fc_contend;
  } frame_query_t;

  typedef struct packed {
    logic valid;
    logic storm_regulated;
    logic vlan_permit;
    logic collision_drop;
    logic drop_nonfc;
    logic flow_ctrl_fc;
  } verdict_t;

  typedef struct packed {
    logic aging_en;
    logic fast_age;
    logic aggressive_backoff;
    logic vlan_strict;
    logic mcast_storm_excl;
    logic bp_carrier;
    logic fair_mode;
    logic no_collision_drop;
  } policy_t;

  typedef enum logic {
    AGE_NORMAL,
    AGE_FAST
  } age_mode_t;

endpackage : switch_policy_pkg

// ==== tb/tb_switch_global_policy_controls.sv ====
// Self-checking bench for the global policy control registers and frame verdicts
`timescale 1ns/1ps
`include "switch_policy_params.svh"
module tb_switch_global_policy_controls;
  // Short aging periods keep the run brief; expectations use these values
  localparam logic [35:0] NORM = 36'd40;
  localparam logic [35:0] FAST = 36'd8;
  logic                            i_clk;
  logic                            i_rst;
  logic [7:0]                      i_addr;
  logic [7:0]                      i_wdata;
  logic                            i_wr;
  logic                            i_rd;
  logic [7:0]                      o_rdata;
  logic                            i_aging_strap_pin;
  logic                            i_backoff_strap_pin;
  logic                            i_collision_drop_strap_pin;
  switch_policy_pkg::frame_query_t i_query;
  switch_policy_pkg::verdict_t     o_verdict;
  switch_policy_pkg::policy_t      o_policy;
  logic                            o_age_tick;
  logic                            o_fast_age_active;
  logic [31:0]                     fail_count;
  logic [31:0]                     n_checks;
  logic [31:0]                     cycles;
  logic [7:0]                      cfg_b;
  logic [31:0]                     n;

  switch_global_policy_controls #(
    .AGE_NORMAL_CYCLES (NORM),
    .AGE_FAST_CYCLES   (FAST)
  ) switch_global_policy_controls_i (
    .i_clk                      (i_clk),
    .i_rst                      (i_rst),
    .i_addr                     (i_addr),
    .i_wdata                    (i_wdata),
    .i_wr                       (i_wr),
    .i_rd                       (i_rd),
    .o_rdata                    (o_rdata),
    .i_aging_strap_pin          (i_aging_strap_pin),
    .i_backoff_strap_pin        (i_backoff_strap_pin),
    .i_collision_drop_strap_pin (i_collision_drop_strap_pin),
    .i_query                    (i_query),
    .o_verdict                  (o_verdict),
    .o_policy                   (o_policy),
    .o_age_tick                 (o_age_tick),
    .o_fast_age_active          (o_fast_age_active)
  );

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 32'd0 && n_checks > 32'd0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // Ceiling well above the expected run of about 1230 cycles
  always @(posedge i_clk) begin
    cycles <= cycles + 32'd1;
    if (cycles == 32'd20000) begin
      fail_count = fail_count + 32'd1;
      final_report();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks = n_checks + 32'd1;
    if (got !== exp) begin
      fail_count = fail_count + 32'd1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk_v(input switch_policy_pkg::verdict_t got,
                       input switch_policy_pkg::verdict_t exp);
    n_checks = n_checks + 32'd1;
    if (got !== exp) begin
      fail_count = fail_count + 32'd1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_v

  task automatic chk_n(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 32'd1;
    if (got !== exp) begin
      fail_count = fail_count + 32'd1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_n

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1;
    chk8(o_rdata, exp);
  endtask : rd_chk

  // Write then read with no idle cycle between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'b0;
    i_rd    <= 1'b1;
    @(posedge i_clk);
    i_rd    <= 1'b0;
    #1;
    chk8(o_rdata, exp);
  endtask : wr_rd

  task automatic reset_with(input logic ag, input logic bo, input logic cd);
    @(posedge i_clk);
    i_aging_strap_pin          <= ag;
    i_backoff_strap_pin        <= bo;
    i_collision_drop_strap_pin <= cd;
    i_rst                      <= 1'b1;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask : reset_with

  task automatic wait_tick(output logic [31:0] cnt);
    cnt = 32'd0;
    do begin
      @(posedge i_clk);
      #1;
      cnt = cnt + 32'd1;
    end while (o_age_tick !== 1'b1 && cnt < 32'd1000);
  endtask : wait_tick

  task automatic run_q(input logic [47:0] da, input logic ku, input logic cr,
                       input logic [4:0] col, input logic fc);
    switch_policy_pkg::verdict_t e;
    logic                        mc;
    mc                = da[`DA_MCAST_BIT];
    e.valid           = 1'b1;
    e.storm_regulated = (da == `DA_BROADCAST) | (mc & ~cfg_b[`B_MC_EXCL]);
    e.vlan_permit     = ~cr | (~cfg_b[`B_VLAN_STRICT] & ku & ~mc);
    e.collision_drop  = (col >= 5'd16) & ~cfg_b[`B_NO_COL_DROP];
    e.drop_nonfc      = fc & cfg_b[`B_FAIR];
    e.flow_ctrl_fc    = fc & ~cfg_b[`B_FAIR];
    @(posedge i_clk);
    i_query <= '{1'b1, da, ku, cr, col, fc};
    @(posedge i_clk);
    i_query <= '0;
    #1;
    chk_v(o_verdict, e);
    @(posedge i_clk);
    #1;
    chk_v(o_verdict, '0);
  endtask : run_q

  task automatic test_straps;
    reset_with(1'b0, 1'b1, 1'b1);
    rd_chk(`ADDR_CTRL_A, 8'h01);
    rd_chk(`ADDR_CTRL_B, 8'hf8);
    reset_with(1'b1, 1'b0, 1'b0);
    rd_chk(`ADDR_CTRL_A, 8'h04);
    rd_chk(`ADDR_CTRL_B, 8'hf0);
    chk8(o_policy, 8'h9e);
  endtask : test_straps

  task automatic test_regs;
    wr(`ADDR_CTRL_A, 8'hff);
    rd_chk(`ADDR_CTRL_A, 8'h07);
    wr(`ADDR_CTRL_B, 8'h5f);
    rd_chk(`ADDR_CTRL_B, 8'h58);
    chk8(o_policy, 8'heb);
    wr(8'h05, 8'hff);
    rd_chk(8'h05, 8'h00);
    rd_chk(`ADDR_CTRL_B, 8'h58);
    wr_rd(`ADDR_CTRL_A, 8'hfa, 8'h02);
    wr(`ADDR_CTRL_A, 8'h04);
  endtask : test_regs

  task automatic test_verdicts;
    // Both settings of every policy bit that steers a verdict
    for (int k = 0; k < 2; k++) begin
      cfg_b = (k == 0) ? 8'hf0 : 8'h28;
      wr(`ADDR_CTRL_B, cfg_b);
      run_q(`DA_BROADCAST, 1'b0, 1'b0, 5'd16, 1'b1);
      run_q(48'h010000000000, 1'b0, 1'b1, 5'd15, 1'b0);
      run_q(48'h001122334455, 1'b1, 1'b1, 5'd17, 1'b1);
      run_q(48'h001122334455, 1'b0, 1'b1, 5'd0, 1'b0);
      run_q(48'h010203040506, 1'b1, 1'b1, 5'd16, 1'b1);
    end
  endtask : test_verdicts

  task automatic test_aging;
    wait_tick(n);
    wait_tick(n);
    chk_n(n, NORM[31:0]);
    wr(`ADDR_CTRL_A, 8'h06);
    wait_tick(n);
    wait_tick(n);
    chk_n(n, FAST[31:0]);
    chk8({7'h0, o_fast_age_active}, 8'h01);
    wr(`ADDR_CTRL_A, 8'h04);
    wait_tick(n);
    wait_tick(n);
    chk_n(n, NORM[31:0]);
    chk8({7'h0, o_fast_age_active}, 8'h00);
    wr(`ADDR_CTRL_A, 8'h00);
    wait_tick(n);
    chk_n(n, 32'd1000);
  endtask : test_aging

  initial begin
    fail_count                 = 32'd0;
    n_checks                   = 32'd0;
    cycles                     = 32'd0;
    cfg_b                      = 8'hf0;
    i_rst                      = 1'b1;
    i_addr                     = 8'h00;
    i_wdata                    = 8'h00;
    i_wr                       = 1'b0;
    i_rd                       = 1'b0;
    i_query                    = '0;
    i_aging_strap_pin          = 1'b1;
    i_backoff_strap_pin        = 1'b0;
    i_collision_drop_strap_pin = 1'b0;
    test_straps();
    test_regs();
    test_verdicts();
    test_aging();
    final_report();
  end
endmodule : tb_switch_global_policy_controls
